/* File: src/sac_pkg.sv */
package sac_pkg;

    // Result width and its reset value
    localparam int RESULT_W = 12;
    localparam logic [11:0] RESULT_RST = 12'h000;

    // System clock period
    localparam int CLK_PERIOD_NS = 100;

    // Longest allowed conversion time, rounded down to whole cycles
    localparam int CONV_TIME_MAX_NS = 1250;
    localparam int CONV_MAX_CYC = CONV_TIME_MAX_NS / CLK_PERIOD_NS;

    // Synchroniser reset value, pins ordered {sel, pd_n, rd_n, conv_n, cs_n}
    localparam int CTRL_W = 5;
    localparam logic [4:0] CTRL_SYNC_RST = 5'h1F;

    // Field positions inside the synchronised control vector
    localparam int CTRL_CS = 0;
    localparam int CTRL_CONV = 1;
    localparam int CTRL_RD = 2;
    localparam int CTRL_PD = 3;
    localparam int CTRL_SEL = 4;

    // Low-power select levels
    localparam logic LP_SLEEP = 1'b0;
    localparam logic LP_NAP = 1'b1;

    typedef enum {
        ST_IDLE,
        ST_CONV
    } sac_state_t;

endpackage

/* File: src/sac_top.sv */
`timescale 1ns/100ps

module sac_top #(
    parameter int DATA_W = sac_pkg::RESULT_W
) (
    input wire logic CLK_SYS,
    input wire logic RESETN,
    input wire logic CS_N,
    input wire logic CONV_START_N,
    input wire logic RD_N,
    input wire logic POWER_DOWN_N,
    input wire logic LOW_POWER_SELECT,
    input wire logic signed [DATA_W-1:0] AIN_POS,
    input wire logic signed [DATA_W-1:0] AIN_NEG,
    output logic [DATA_W-1:0] RESULT_O,
    output logic [DATA_W-1:0] RESULT_OE,
    output logic BUSY_N,
    output logic NAP_ACTIVE,
    output logic SLEEP_ACTIVE
);
    import sac_pkg::*;

    localparam int IDX_W = $clog2(DATA_W);
    localparam logic [IDX_W-1:0] MSB_IDX = IDX_W'(DATA_W - 1);

    // One trial per clock must fit inside the longest conversion time
    if (DATA_W < 2 || DATA_W > CONV_MAX_CYC) begin : g_bad_width
        $error("DATA_W out of range for the conversion time");
    end

    logic [CTRL_W-1:0] ctrl_s1_q;
    logic [CTRL_W-1:0] ctrl_s2_q;
    logic [DATA_W-1:0] pos_s1_q;
    logic [DATA_W-1:0] pos_s2_q;
    logic [DATA_W-1:0] neg_s1_q;
    logic [DATA_W-1:0] neg_s2_q;
    logic conv_prev_q;

    sac_state_t state_q;
    sac_state_t state_d;
    logic [IDX_W-1:0] bit_idx_q;
    logic [IDX_W-1:0] bit_idx_d;
    logic [DATA_W-1:0] bit_trial_q;
    logic [DATA_W-1:0] bit_trial_d;
    logic [DATA_W-1:0] held_q;
    logic [DATA_W-1:0] held_d;
    logic [DATA_W-1:0] result_q;
    logic [DATA_W-1:0] result_d;
    logic busy_n_q;
    logic busy_n_d;
    logic nap_q;
    logic sleep_q;

    // Pins are asynchronous to CLK_SYS; the analog codes are held steady
    // by the source around a start, so a per-bit sync is good enough.
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            ctrl_s1_q <= CTRL_SYNC_RST;
            ctrl_s2_q <= CTRL_SYNC_RST;
            conv_prev_q <= 1'b1;
        end else begin
            ctrl_s1_q <= {LOW_POWER_SELECT, POWER_DOWN_N, RD_N, CONV_START_N, CS_N};
            ctrl_s2_q <= ctrl_s1_q;
            conv_prev_q <= ctrl_s2_q[CTRL_CONV];
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            pos_s1_q <= '0;
            pos_s2_q <= '0;
            neg_s1_q <= '0;
            neg_s2_q <= '0;
        end else begin
            pos_s1_q <= AIN_POS;
            pos_s2_q <= pos_s1_q;
            neg_s1_q <= AIN_NEG;
            neg_s2_q <= neg_s1_q;
        end
    end

    wire cs_low = ~ctrl_s2_q[CTRL_CS];
    wire conv_n = ctrl_s2_q[CTRL_CONV];
    wire rd_low = ~ctrl_s2_q[CTRL_RD];
    wire pd_low = ~ctrl_s2_q[CTRL_PD];
    wire lp_sel = ctrl_s2_q[CTRL_SEL];
    wire idle = (state_q == ST_IDLE);

    wire conv_fall = conv_prev_q & ~conv_n;

    // idle-only start
    // A start during power-down is dropped: the comparator is not awake.
    wire start_ok = conv_fall & cs_low & ~pd_low & idle;

    wire [DATA_W:0] diff_full = {pos_s2_q[DATA_W-1], pos_s2_q} - {neg_s2_q[DATA_W-1], neg_s2_q};
    wire diff_ovf = diff_full[DATA_W] ^ diff_full[DATA_W-1];
    wire [DATA_W-1:0] diff_sat = diff_ovf ? {diff_full[DATA_W], {(DATA_W-1){~diff_full[DATA_W]}}}
                                          : diff_full[DATA_W-1:0];

    wire [DATA_W-1:0] sample_u = {~diff_sat[DATA_W-1], diff_sat[DATA_W-2:0]};

    wire [DATA_W-1:0] trial_bit = DATA_W'(1) << bit_idx_q;
    wire [DATA_W-1:0] trial_word = bit_trial_q | trial_bit;
    wire keep_bit = (held_q >= trial_word);
    wire [DATA_W-1:0] next_word = keep_bit ? trial_word : bit_trial_q;
    wire last_bit = (bit_idx_q == '0);

    always_comb begin
        state_d = state_q;
        bit_idx_d = bit_idx_q;
        bit_trial_d = bit_trial_q;
        held_d = held_q;
        result_d = result_q;
        busy_n_d = busy_n_q;
        case (state_q)
            ST_IDLE: begin
                if (start_ok) begin
                    bit_trial_d = '0;
                    bit_idx_d = MSB_IDX;
                    held_d = sample_u;
                    busy_n_d = 1'b0;
                    state_d = ST_CONV;
                end
            end
            ST_CONV: begin
                bit_trial_d = next_word;
                if (last_bit) begin
                    result_d = {~next_word[DATA_W-1], next_word[DATA_W-2:0]};
                    busy_n_d = 1'b1;
                    state_d = ST_IDLE;
                end else begin
                    bit_idx_d = bit_idx_q - IDX_W'(1);
                end
            end
            default: begin
                state_d = ST_IDLE;
                busy_n_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            state_q <= ST_IDLE;
            busy_n_q <= 1'b1;
            bit_idx_q <= '0;
        end else begin
            state_q <= state_d;
            busy_n_q <= busy_n_d;
            bit_idx_q <= bit_idx_d;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            bit_trial_q <= '0;
            held_q <= '0;
            result_q <= DATA_W'(RESULT_RST);
        end else begin
            bit_trial_q <= bit_trial_d;
            held_q <= held_d;
            result_q <= result_d;
        end
    end

    wire nap_d = pd_low & (lp_sel == LP_NAP);
    wire sleep_d = pd_low & (lp_sel == LP_SLEEP);

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            nap_q <= 1'b0;
            sleep_q <= 1'b0;
        end else begin
            nap_q <= nap_d;
            sleep_q <= sleep_d;
        end
    end

    // drive only on read with select
    wire drive_en = rd_low & cs_low;

    assign RESULT_OE = {DATA_W{drive_en}};
    assign RESULT_O = result_q;
    assign BUSY_N = busy_n_q;
    assign NAP_ACTIVE = nap_q;
    assign SLEEP_ACTIVE = sleep_q;

    // Busy low-time counter for the checks below.
    // A long repetition would be unrolled by the tools; a counter stays cheap.
    localparam logic [IDX_W:0] RUN_LEN = (IDX_W+1)'(DATA_W);
    logic [IDX_W:0] busy_low_cnt_q;
    logic [IDX_W:0] busy_low_cnt_d;

    assign busy_low_cnt_d = BUSY_N ? '0 : busy_low_cnt_q + (IDX_W+1)'(1);

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            busy_low_cnt_q <= '0;
        end else begin
            busy_low_cnt_q <= busy_low_cnt_d;
        end
    end

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RESETN);

    sequence s_conv_run;
        !BUSY_N && (busy_low_cnt_q < RUN_LEN);
    endsequence

    sequence s_conv_done;
        BUSY_N && idle && (busy_low_cnt_q == RUN_LEN);
    endsequence

    property p_start;
        start_ok |=> !BUSY_N && (state_q == ST_CONV);
    endproperty
    a_start: assert property (p_start) else $error("conversion did not start");

    property p_cs_gate;
        (idle && !cs_low) |=> BUSY_N && idle;
    endproperty
    a_cs_gate: assert property (p_cs_gate) else $error("start taken without chip select");

    property p_drive;
        !(rd_low && cs_low) |-> (RESULT_OE == '0);
    endproperty
    a_drive: assert property (p_drive) else $error("result driven outside read");

    property p_busy_len;
        $rose(BUSY_N) |-> s_conv_done;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy low time wrong");

    property p_busy_run;
        !BUSY_N |-> s_conv_run;
    endproperty
    a_busy_run: assert property (p_busy_run) else $error("busy held low too long");

    property p_result;
        $rose(BUSY_N) |-> (RESULT_O == {~held_q[DATA_W-1], held_q[DATA_W-2:0]});
    endproperty
    a_result: assert property (p_result) else $error("result wrong at busy rise");

    property p_mode;
        (pd_low && lp_sel) |=> NAP_ACTIVE && !SLEEP_ACTIVE;
    endproperty
    a_mode: assert property (p_mode) else $error("nap not entered");

    property p_sleep;
        (pd_low && !lp_sel) |=> SLEEP_ACTIVE && !NAP_ACTIVE;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep not entered");

    property p_no_restart;
        (state_q == ST_CONV) |=> $stable(held_q);
    endproperty
    a_no_restart: assert property (p_no_restart) else $error("conversion restarted");

    property p_clear;
        start_ok |=> (bit_trial_q == '0) && (bit_idx_q == MSB_IDX);
    endproperty
    a_clear: assert property (p_clear) else $error("trial register not cleared");

    property p_order;
        (state_q == ST_CONV && !last_bit) |=> (bit_idx_q == $past(bit_idx_q) - IDX_W'(1));
    endproperty
    a_order: assert property (p_order) else $error("bit order wrong");

    property p_hold;
        !$rose(BUSY_N) |-> $stable(RESULT_O);
    endproperty
    a_hold: assert property (p_hold) else $error("result changed without conversion");

endmodule // sac_top

/* File: verif/sac_bus_model.sv */
`timescale 1ns/100ps
// Host view of the three-state result lines
module sac_bus_model (
    input wire logic clk_sys,
    input wire logic [sac_pkg::RESULT_W-1:0] result_o,
    input wire logic [sac_pkg::RESULT_W-1:0] result_oe,
    output logic [sac_pkg::RESULT_W-1:0] bus
);
    import sac_pkg::*;
    logic [RESULT_W-1:0] last_q = 12'h000;
    // Released bits flip every cycle, so a stale value never passes for read data
    always_comb begin
        for (int i = 0; i < RESULT_W; i++) begin
            bus[i] = result_oe[i] ? result_o[i] : ~last_q[i];
        end
    end
    always_ff @(posedge clk_sys) begin
        last_q <= bus;
    end
endmodule // sac_bus_model

/* File: verif/sac_top_test.sv */
`timescale 1ns/100ps
module sac_top_test;
    import sac_pkg::*;
    logic clk_sys = 0, resetn = 0, cs_n = 1, conv_n = 1, rd_n = 1, pd_n = 1, sel = 0;
    logic signed [11:0] ain_pos = 12'sh000, ain_neg = 12'sh000;
    logic [11:0] result_o, result_oe, bus;
    logic busy_n, nap_active, sleep_active;
    int n_mismatch = 0, n_checks = 0, cyc = 0;
    always #50 clk_sys = ~clk_sys;
    sac_top sac_top_i(.CLK_SYS(clk_sys), .RESETN(resetn), .CS_N(cs_n), .CONV_START_N(conv_n),
        .RD_N(rd_n), .POWER_DOWN_N(pd_n), .LOW_POWER_SELECT(sel), .AIN_POS(ain_pos), .AIN_NEG(ain_neg),
        .RESULT_O(result_o), .RESULT_OE(result_oe), .BUSY_N(busy_n), .NAP_ACTIVE(nap_active),
        .SLEEP_ACTIVE(sleep_active));
    sac_bus_model sac_bus_model_i(.clk_sys(clk_sys), .result_o(result_o), .result_oe(result_oe), .bus(bus));
    task results;
        if (n_mismatch == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Tests take under 200 cycles
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            results();
        end
    end
    task chk(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task conv(input logic [11:0] p, input logic [11:0] n, input logic [11:0] exp, input logic mid,
            input logic [11:0] old);
        int k;
        int t0;
        @(posedge clk_sys);
        ain_pos <= p;
        ain_neg <= n;
        cs_n <= 1'b0;
        @(posedge clk_sys);
        conv_n <= 1'b0;
        @(posedge clk_sys);
        conv_n <= 1'b1;
        k = 0;
        while (busy_n !== 1'b0 && k < 10) begin
            @(negedge clk_sys);
            k++;
        end
        t0 = cyc;
        chk({11'h000, busy_n}, 12'h000);
        if (mid) begin
            @(posedge clk_sys);
            conv_n <= 1'b0;
            rd_n <= 1'b0;
            repeat (3) @(negedge clk_sys);
            chk(bus, old);
            @(posedge clk_sys);
            rd_n <= 1'b1;
        end
        k = 0;
        while (busy_n === 1'b0 && k < 20) begin
            @(negedge clk_sys);
            k++;
        end
        chk(12'(cyc - t0), 12'h00C);
        chk(result_o, exp);
        if (mid) begin
            repeat (5) @(negedge clk_sys);
            chk({11'h000, busy_n}, 12'h001);
            @(posedge clk_sys);
            conv_n <= 1'b1;
        end
        repeat (3) @(posedge clk_sys);
    endtask
    task rd(input logic c, input logic [11:0] exp_oe, input logic [11:0] exp);
        @(posedge clk_sys);
        cs_n <= c;
        rd_n <= 1'b0;
        repeat (3) @(negedge clk_sys);
        chk(result_oe, exp_oe);
        if (exp_oe[0])
            chk(bus, exp);
        @(posedge clk_sys);
        rd_n <= 1'b1;
        cs_n <= 1'b0;
        repeat (3) @(negedge clk_sys);
        chk(result_oe, 12'h000);
    endtask
    initial begin
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (3) @(negedge clk_sys);
        chk({result_oe[0], busy_n, nap_active, sleep_active}, 12'h004);
        rd(1'b0, 12'hFFF, 12'h000);
        conv(12'h064, 12'hFCE, 12'h096, 1'b0, 12'h000);
        rd(1'b0, 12'hFFF, 12'h096);
        rd(1'b1, 12'h000, 12'h000);
        conv(12'h000, 12'h001, 12'hFFF, 1'b1, 12'h096);
        conv(12'h001, 12'h001, 12'h000, 1'b0, 12'h000);
        conv(12'h7FF, 12'h800, 12'h7FF, 1'b0, 12'h000);
        conv(12'hA5A, 12'h000, 12'hA5A, 1'b0, 12'h000);
        // Start pulse with chip select high must be dropped
        @(posedge clk_sys);
        cs_n <= 1'b1;
        conv_n <= 1'b0;
        repeat (8) @(negedge clk_sys);
        chk({11'h000, busy_n}, 12'h001);
        @(posedge clk_sys);
        conv_n <= 1'b1;
        cs_n <= 1'b0;
        for (int s = 0; s < 2; s++) begin
            @(posedge clk_sys);
            sel <= s[0];
            @(posedge clk_sys);
            pd_n <= 1'b0;
            repeat (4) @(negedge clk_sys);
            chk({10'h000, nap_active, sleep_active}, s ? 12'h002 : 12'h001);
            @(posedge clk_sys);
            pd_n <= 1'b1;
            repeat (4) @(negedge clk_sys);
            chk({10'h000, nap_active, sleep_active}, 12'h000);
        end
        rd(1'b0, 12'hFFF, 12'hA5A);
        results();
    end
endmodule // sac_top_test
